/* core/lsd_pkg.sv */
// constants, types and reset state for the led sink mode and error readout block
// assumes one 50 MHz clock and software access over ahb-lite
package lsd_pkg;

  localparam int NCH = 8;
  localparam int CLK_PERIOD_NS = 20;
  // status from the analogue detectors is trusted only this long after enable falls
  localparam int STATUS_VALID_NS = 2000;
  localparam logic [6:0] STATUS_VALID_CYC =
    7'((STATUS_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] DET_CNT_STEP = 7'h01;

  // configuration code layout, shifted in most significant bit first
  localparam logic [7:0] CFG_RESET = 8'hFF;
  localparam int CFG_RANGE_POS = 0;
  localparam int CFG_BAND_POS = 1;
  localparam int CFG_MANT_LSB = 2;
  localparam int CFG_MANT_MSB = 7;

  // low samples of the enable before the shift input turns to the status code
  localparam logic [1:0] LOW_CNT_LOAD = 2'h2;
  localparam logic [1:0] LOW_CNT_STEP = 2'h1;

  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam int CTRL_SHORT_POS = 0;
  localparam int STAT_MODE_POS = 0;
  localparam int STAT_DET_POS = 1;
  localparam int STAT_SW_POS = 2;
  localparam int STAT_CFG_LSB = 8;
  localparam int STAT_ERR_LSB = 16;
  localparam int STAT_LAT_LSB = 24;
  localparam int HTRANS_ACT_POS = 1;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic {LSD_NORMAL, LSD_SPECIAL} lsd_mode_t;
  typedef enum logic [1:0] {LSD_SW_IDLE, LSD_SW_A, LSD_SW_B} lsd_sw_t;

  typedef struct packed {
    logic sclk;
    logic sin;
    logic latch;
    logic oe_n;
  } lsd_pins_t;

  // analogue comparator and sensor results, one bit per channel except the single global_hot bit
  typedef struct packed {
    logic [NCH-1:0] current_ok;
    logic [NCH-1:0] v_trip;
    logic [NCH-1:0] v_release;
    logic [NCH-1:0] chan_hot;
    logic global_hot;
  } lsd_analog_t;

  localparam lsd_pins_t PINS_IDLE = '{sclk: 1'b0, sin: 1'b0, latch: 1'b0, oe_n: 1'b1};

  typedef struct packed {
    lsd_pins_t s1;
    lsd_pins_t s2;
    lsd_pins_t s3;
    lsd_pins_t filt;
    lsd_mode_t mode;
    lsd_sw_t sw;
    logic oe_prev2;
    logic oe_prev1;
    logic [1:0] low_cnt;
    logic [6:0] det_cnt;
    logic [NCH-1:0] shreg;
    logic [NCH-1:0] out_latch;
    logic [NCH-1:0] cfg;
    logic [NCH-1:0] err;
    logic [NCH-1:0] ot_seen;
    logic [NCH-1:0] sink;
    logic sout;
    logic ctrl_short;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic readyout;
  } lsd_state_t;

  localparam lsd_state_t ST_RESET = '{
    s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE, filt: PINS_IDLE,
    mode: LSD_NORMAL, sw: LSD_SW_IDLE, oe_prev2: 1'b1, oe_prev1: 1'b1,
    cfg: CFG_RESET, readyout: 1'b1, default: '0};

endpackage

/* core/lsd_core.sv */
// led sink driver control: serial shift path, mode switching, error readout
// assumes the pin inputs are asynchronous to hclk; analogue results are hclk-synchronous
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps

// Overview of operation
// R1: enable sampled high, low, high on three serial edges starts a two-edge switch phase.
// R2: latch strobe sampled at the fourth edge picks special mode if high, else normal.
// R3: latch strobe copies nothing between the third and fifth edges of a switch.
// R4: the short enable pulse of a switch still turns the sinks on.
// R5: shifting from serial_in to serial_out continues during the switch phase.
// R6: after reset the block is in normal mode.
// R7: normal mode shifts data, strobe fills output latch, low enable turns sinks on.
// R8: special mode with enable not low shifts serial data as in normal mode.
// R9: controller holds enable low for at least three sampled edges to detect errors.
// R10: after the second low sample the shift input becomes the status code.
// R11: third and later low samples load status; status settles two microseconds after enable falls.
// R12: serial_in is ignored from the third low sample on while enable is low in special mode.
// R13: enable high again restores serial input, stops sinks and detection, status shifts out.
// R14: in special mode the strobe fills the configuration latch instead.
// R15: configuration code is kept until reset or the next configuration write.
// R16: configuration writes use the same shift and strobe timing as normal data.
// R17: controller orders detection and configuration so status is never latched as configuration.
// R18: channel status is 1 when on with current at or above half target, else 0.
// R19: short variant: voltage at trip reads 0, below release reads 1 only with current ok, off reads 0.
// R20: global overheat stops all channels and stores 0 for all; restart after cooling.
// R21: channel overheat while on stops that channel and stores 0; restart after cooling.
// R22: returning to normal mode clears all stored status.
// R23: configuration is msb first; bit 0 range, bit 1 band, bits 2-7 mantissa; reset ones.
// R24: a channel sinks only with its latch bit set, enable low and no overheat.
// R25: eight-bit shift register, serial_out from the last stage for cascading.
module lsd_core (
  input wire logic hclk, // system clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, words only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response
  input lsd_pkg::lsd_pins_t pin_in, // serial clock, data, strobe, enable pins
  input lsd_pkg::lsd_analog_t fe, // analogue detector results
  output logic serial_out, // cascade output
  output logic [lsd_pkg::NCH-1:0] sink_on, // per-channel sink drive
  output logic current_range_select, // configuration bit 0
  output logic gain_band_select, // configuration bit 1
  output logic [5:0] gain_mantissa // configuration bits 2 to 7
);

  lsd_pkg::lsd_state_t st;
  lsd_pkg::lsd_state_t nx;
  logic edge_s;
  logic pulse_s;
  logic latch_en;
  logic load_now;
  logic det_act;
  logic [lsd_pkg::NCH-1:0] det_bit;
  logic [lsd_pkg::NCH-1:0] trip_bit;
  logic [lsd_pkg::NCH-1:0] sink_nx;
  logic [lsd_pkg::NCH-1:0] shift_exp;
  logic [lsd_pkg::NCH-1:0] load_val;

  // per-channel status, overheat and sink decisions
  genvar gi;
  generate
    for (gi = 0; gi < lsd_pkg::NCH; gi++) begin : g_ch
      logic on_cmd;
      logic open_ok;
      assign on_cmd = st.out_latch[gi] & ~st.filt.oe_n; // see R24
      assign open_ok = st.sink[gi] & fe.current_ok[gi]; // see R18
      // between the two short thresholds the last result stands (hysteresis)
      assign det_bit[gi] = ~st.ctrl_short ? open_ok :
                           fe.v_trip[gi] ? 1'b0 :
                           fe.v_release[gi] ? open_ok :
                           (st.err[gi] & st.sink[gi]); // see R19
      assign trip_bit[gi] = fe.global_hot | (fe.chan_hot[gi] & on_cmd); // see R20 see R21
      // restart after cooling needs no state: drive simply returns with the command
      assign sink_nx[gi] = on_cmd & ~fe.global_hot & ~fe.chan_hot[gi]; // see R4 see R24
    end
  endgenerate

  always_comb begin
    nx = st;
    nx.s1 = pin_in;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    // a pin change counts once the second and third stages agree
    nx.filt = lsd_pkg::lsd_pins_t'((st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3)));
    edge_s = nx.filt.sclk & ~st.filt.sclk;
    pulse_s = edge_s & st.oe_prev2 & ~st.oe_prev1 & nx.filt.oe_n; // see R1
    shift_exp = {st.shreg[lsd_pkg::NCH-2:0], nx.filt.sin};
    load_val = st.err & ~st.ot_seen;
    load_now = (st.mode == lsd_pkg::LSD_SPECIAL) & ~nx.filt.oe_n &
               (st.low_cnt >= lsd_pkg::LOW_CNT_LOAD);
    det_act = (st.mode == lsd_pkg::LSD_SPECIAL) & ~st.filt.oe_n;

    if (edge_s) begin
      nx.oe_prev2 = st.oe_prev1;
      nx.oe_prev1 = nx.filt.oe_n;
      case (st.sw)
        lsd_pkg::LSD_SW_IDLE: begin
          if (pulse_s) begin
            nx.sw = lsd_pkg::LSD_SW_A; // see R1
          end
        end
        lsd_pkg::LSD_SW_A: begin
          nx.sw = lsd_pkg::LSD_SW_B;
          nx.mode = nx.filt.latch ? lsd_pkg::LSD_SPECIAL : lsd_pkg::LSD_NORMAL; // see R2
        end
        lsd_pkg::LSD_SW_B: begin
          nx.sw = lsd_pkg::LSD_SW_IDLE;
        end
        default: begin
          nx.sw = lsd_pkg::LSD_SW_IDLE;
        end
      endcase
      if (load_now) begin
        nx.shreg = load_val; // see R10 see R11 see R12
      end else begin
        nx.shreg = shift_exp; // see R5 see R7 see R8 see R13
      end
      if ((st.mode == lsd_pkg::LSD_SPECIAL) & ~nx.filt.oe_n) begin
        if (st.low_cnt < lsd_pkg::LOW_CNT_LOAD) begin
          nx.low_cnt = st.low_cnt + lsd_pkg::LOW_CNT_STEP;
        end
      end else begin
        nx.low_cnt = '0;
      end
    end
    nx.sout = nx.shreg[lsd_pkg::NCH-1]; // see R25

    // strobe is a level; it is held off for the whole switch phase
    latch_en = nx.filt.latch & (nx.sw == lsd_pkg::LSD_SW_IDLE) & ~pulse_s; // see R3
    if (latch_en) begin
      if (st.mode == lsd_pkg::LSD_SPECIAL) begin
        nx.cfg = st.shreg; // see R14 see R15 see R16
      end else begin
        nx.out_latch = st.shreg; // see R7
      end
    end

    // detection timer runs on hclk from the fall of the enable
    if (det_act) begin
      if (st.det_cnt < lsd_pkg::STATUS_VALID_CYC) begin
        nx.det_cnt = st.det_cnt + lsd_pkg::DET_CNT_STEP;
      end else begin
        nx.err = det_bit; // see R11 see R18
      end
    end else begin
      nx.det_cnt = '0; // see R13
    end

    if ((st.mode == lsd_pkg::LSD_SPECIAL) & (nx.mode == lsd_pkg::LSD_NORMAL)) begin
      nx.err = '0; // see R22
      nx.ot_seen = '0;
    end
    // an overheat in the same cycle as the clear still sticks
    nx.ot_seen = nx.ot_seen | trip_bit; // see R20 see R21
    nx.err = nx.err & ~trip_bit;
    nx.sink = sink_nx;

    // ahb-lite slave, zero wait states, always okay
    nx.readyout = 1'b1;
    nx.wr_pend = hsel & hready & htrans[lsd_pkg::HTRANS_ACT_POS] & hwrite;
    if (hsel & hready & htrans[lsd_pkg::HTRANS_ACT_POS]) begin
      nx.wr_addr = haddr[7:0];
    end
    if (st.wr_pend & (st.wr_addr == lsd_pkg::ADDR_CTRL)) begin
      nx.ctrl_short = hwdata[lsd_pkg::CTRL_SHORT_POS];
    end
    if (hsel & hready & htrans[lsd_pkg::HTRANS_ACT_POS] & ~hwrite) begin
      nx.rdata = '0;
      if (haddr[7:0] == lsd_pkg::ADDR_CTRL) begin
        nx.rdata[lsd_pkg::CTRL_SHORT_POS] = st.ctrl_short;
      end else if (haddr[7:0] == lsd_pkg::ADDR_STAT) begin
        nx.rdata[lsd_pkg::STAT_MODE_POS] = (st.mode == lsd_pkg::LSD_SPECIAL);
        nx.rdata[lsd_pkg::STAT_DET_POS] = det_act;
        nx.rdata[lsd_pkg::STAT_SW_POS] = (st.sw != lsd_pkg::LSD_SW_IDLE);
        nx.rdata[lsd_pkg::STAT_CFG_LSB +: lsd_pkg::NCH] = st.cfg;
        nx.rdata[lsd_pkg::STAT_ERR_LSB +: lsd_pkg::NCH] = load_val;
        nx.rdata[lsd_pkg::STAT_LAT_LSB +: lsd_pkg::NCH] = st.out_latch;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= lsd_pkg::ST_RESET; // see R6 see R23
    end else begin
      st <= nx;
    end
  end

  assign hrdata = st.rdata;
  assign hreadyout = st.readyout;
  assign hresp = lsd_pkg::HRESP_OKAY;
  assign serial_out = st.sout;
  assign sink_on = st.sink;
  assign current_range_select = st.cfg[lsd_pkg::CFG_RANGE_POS]; // see R23
  assign gain_band_select = st.cfg[lsd_pkg::CFG_BAND_POS];
  assign gain_mantissa = st.cfg[lsd_pkg::CFG_MANT_MSB:lsd_pkg::CFG_MANT_LSB];

  // checks
  a_pulse_enters_switch: assert property (@(posedge hclk) disable iff (!hresetn) // see R1
    pulse_s && st.sw == lsd_pkg::LSD_SW_IDLE |=> st.sw == lsd_pkg::LSD_SW_A)
    else $error("mode pulse did not open the switch phase");
  a_fourth_edge_special: assert property (@(posedge hclk) disable iff (!hresetn) // see R2
    edge_s && st.sw == lsd_pkg::LSD_SW_A && nx.filt.latch |=> st.mode == lsd_pkg::LSD_SPECIAL)
    else $error("high strobe at fourth edge did not select special");
  a_fourth_edge_normal: assert property (@(posedge hclk) disable iff (!hresetn) // see R2
    edge_s && st.sw == lsd_pkg::LSD_SW_A && !nx.filt.latch |=> st.mode == lsd_pkg::LSD_NORMAL)
    else $error("low strobe at fourth edge did not select normal");
  a_no_latch_switch: assert property (@(posedge hclk) disable iff (!hresetn) // see R3
    st.sw != lsd_pkg::LSD_SW_IDLE && !edge_s |=> $stable(st.out_latch) && $stable(st.cfg))
    else $error("latch changed during switch phase");
  a_sink_needs_enable: assert property (@(posedge hclk) disable iff (!hresetn) // see R24
    |st.sink |-> $past(!st.filt.oe_n))
    else $error("sink on without enable low");
  a_shift_serial: assert property (@(posedge hclk) disable iff (!hresetn) // see R5
    edge_s && !load_now |=> st.shreg == $past(shift_exp) &&
      serial_out == st.shreg[lsd_pkg::NCH-1])
    else $error("serial shift lost a bit");
  a_load_status: assert property (@(posedge hclk) disable iff (!hresetn) // see R11
    edge_s && load_now |=> st.shreg == $past(load_val))
    else $error("status code not loaded on low sample");
  a_cfg_write: assert property (@(posedge hclk) disable iff (!hresetn) // see R14
    latch_en && st.mode == lsd_pkg::LSD_SPECIAL |=> st.cfg == $past(st.shreg))
    else $error("special strobe did not write configuration");
  a_err_clear_normal: assert property (@(posedge hclk) disable iff (!hresetn) // see R22
    st.mode == lsd_pkg::LSD_NORMAL && $past(st.mode) == lsd_pkg::LSD_SPECIAL |-> st.err == '0)
    else $error("status survived return to normal");
  a_global_hot_off: assert property (@(posedge hclk) disable iff (!hresetn) // see R20
    fe.global_hot |=> st.sink == '0 && st.ot_seen == '1 ##1 load_val == '0)
    else $error("global overheat did not stop all channels");
  c_enter_special: cover property (@(posedge hclk) disable iff (!hresetn)
    st.mode == lsd_pkg::LSD_NORMAL ##1 st.mode == lsd_pkg::LSD_SPECIAL);
  c_status_load: cover property (@(posedge hclk) disable iff (!hresetn)
    edge_s && load_now && load_val != '0);
  c_cfg_write: cover property (@(posedge hclk) disable iff (!hresetn)
    latch_en && st.mode == lsd_pkg::LSD_SPECIAL);

endmodule

/* bench/lsd_ctl_model.sv */
// controller model that drives the serial pins of the led sink block
// assumes the caller enters each task just after a rising hclk edge
`timescale 1ns/1ps
module lsd_ctl_model (
  input wire logic hclk, // bench clock
  output lsd_pkg::lsd_pins_t pins // serial clock, data, strobe, enable
);
  initial pins = lsd_pkg::PINS_IDLE;

  task automatic wait_clk(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // the block filters its pins through flops, so each level stands 5 hclk around the rise
  // serial clock rests low between edges and frames
  task automatic bit_edge(input logic d, input logic le, input logic oe);
    pins.sin <= d;
    pins.latch <= le;
    pins.oe_n <= oe;
    wait_clk(5);
    pins.sclk <= 1'b1;
    wait_clk(5);
    pins.sclk <= 1'b0;
    wait_clk(5);
  endtask

  // one strobe shape for output data and configuration alike
  task automatic strobe();
    pins.latch <= 1'b1;
    wait_clk(6);
    pins.latch <= 1'b0;
    wait_clk(6);
  endtask

  task automatic set_oe(input logic oe);
    pins.oe_n <= oe;
    wait_clk(8);
  endtask
endmodule

/* bench/test_led_sink_mode_and_error_readout.sv */
// self-checking bench: ahb registers, serial path, mode switching, error readout
// assumes lsd_pkg, lsd_core and the controller model are compiled first
`timescale 1ns/1ps
module test_led_sink_mode_and_error_readout;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  lsd_pkg::lsd_pins_t pins;
  lsd_pkg::lsd_analog_t fe = '0;
  logic serial_out;
  logic [7:0] sink_on;
  logic current_range_select;
  logic gain_band_select;
  logic [5:0] gain_mantissa;
  logic [31:0] rng = 32'h7F5DBCEA;
  logic [31:0] rd;
  int miscompares = 0;
  int check_count = 0;
  int sh = 0;
  int lat = 0;

  always #10 hclk = ~hclk;

  lsd_core i_lsd_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pins), .fe(fe),
    .serial_out(serial_out), .sink_on(sink_on), .current_range_select(current_range_select),
    .gain_band_select(gain_band_select), .gain_mantissa(gain_mantissa));
  lsd_ctl_model u_ctl (.hclk(hclk), .pins(pins));

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin
      miscompares++;
      wrap_up();
    end
  endtask

  // one serial edge; the model shifts msb first and the last stage shows on serial_out
  task automatic tb_bit(input logic d, input logic le, input logic oe);
    u_ctl.bit_edge(d, le, oe);
    sh = ((sh << 1) | int'(d)) & 255;
    chk("serial_out", serial_out, 32'(sh >> 7));
  endtask

  // enable high, low, high on three edges; strobe level at the fourth edge picks the mode
  task automatic mode_sw(input logic sel);
    logic [4:0] r;
    r = 5'(rnd());
    for (int i = 0; i < 5; i++) begin
      tb_bit(r[i], sel && i == 3, i != 1);
      if (i == 1) chk("sink_pulse", 32'(sink_on), 32'(lat));
    end
    ahb(1'b0, lsd_pkg::ADDR_STAT, 32'h0);
    chk("mode", 32'(rd[0]), 32'(sel));
    chk("out_latch_kept", 32'(rd[31:24]), 32'(lat));
  endtask

  initial begin
    int b;
    logic [7:0] vt;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("sink_rst", 32'(sink_on), 32'h0);
    chk("cfg_rst", {24'h0, gain_mantissa, gain_band_select, current_range_select}, 32'hFF);
    chk("hresp", 32'(hresp), 32'h0);
    ahb(1'b0, lsd_pkg::ADDR_STAT, 32'h0);
    chk("mode_rst", 32'(rd[0]), 32'h0);
    ahb(1'b1, lsd_pkg::ADDR_CTRL, 32'h1);
    ahb(1'b0, lsd_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    ahb(1'b1, lsd_pkg::ADDR_CTRL, 32'h0);
    ahb(1'b0, 8'h08, 32'h0);
    chk("unmapped", rd, 32'h0);
    b = int'(rnd() & 32'hFF);
    for (int i = 7; i >= 0; i--) tb_bit(b[i], 1'b0, 1'b1);
    u_ctl.strobe();
    lat = sh;
    ahb(1'b0, lsd_pkg::ADDR_STAT, 32'h0);
    chk("out_latch", 32'(rd[31:24]), 32'(lat));
    u_ctl.set_oe(1'b0);
    chk("sink_on", 32'(sink_on), 32'(lat));
    mode_sw(1'b1);
    b = int'(rnd() & 32'hFF);
    for (int i = 7; i >= 0; i--) tb_bit(b[i], 1'b0, 1'b1);
    u_ctl.strobe();
    chk("cfg", {24'h0, gain_mantissa, gain_band_select, current_range_select}, 32'(b));
    ahb(1'b0, lsd_pkg::ADDR_STAT, 32'h0);
    chk("latches", 32'({rd[31:24], rd[15:8]}), 32'((lat << 8) | b));
    // detection only after the configuration strobe, so status never lands in it
    for (int p = 0; p < 3; p++) begin
      if (p == 2) begin
        mode_sw(1'b0);
        mode_sw(1'b1);
      end
      // first pass runs the short-detect variant with random trip levels
      if (p == 0) ahb(1'b1, lsd_pkg::ADDR_CTRL, 32'h1);
      vt = (p == 0) ? 8'(rnd()) : 8'h0;
      fe.v_trip <= vt;
      fe.v_release <= ~vt;
      fe.current_ok <= 8'(rnd());
      fe.global_hot <= (p == 1);
      tb_bit(1'(rnd()), 1'b0, 1'b0);
      tb_bit(1'(rnd()), 1'b0, 1'b0);
      u_ctl.wait_clk(110);
      u_ctl.bit_edge(1'(rnd()), 1'b0, 1'b0);
      sh = (p == 1) ? 0 : (lat & int'(fe.current_ok) & int'(~vt));
      chk("status", 32'(serial_out), 32'(sh >> 7));
      chk("sink_hot", 32'(sink_on), (p == 1) ? 32'h0 : 32'(lat));
      fe.global_hot <= 1'b0;
      u_ctl.wait_clk(10);
      chk("sink_cool", 32'(sink_on), 32'(lat));
      for (int i = 0; i < 8; i++) tb_bit(1'(rnd()), 1'b0, 1'b1);
      chk("sink_off", 32'(sink_on), 32'h0);
    end
    wrap_up();
  end
endmodule
